// File: hw/sacs_pkg.sv
// constants and types shared by the conversion sequencer files
package sacs_pkg;
    // system clock
    localparam int MCLK_PERIOD_NS = 25;        // 40 MHz system clock
    localparam int MCLK_KHZ       = 1000000 / MCLK_PERIOD_NS;
    // nominal internal oscillator rate, matches the 4 MHz accuracy point
    localparam int OSC_KHZ        = 4000;
    // half period of the internal oscillator in system clocks
    localparam int OSC_HALF_INT   = MCLK_KHZ / (2 * OSC_KHZ);
    localparam logic [3:0] OSC_HALF = 4'(OSC_HALF_INT);
    localparam logic [3:0] OSC_CNT_RST = 4'h0;

    // conversion timing, counted in selected clock falling edges
    localparam logic [4:0] FALL_RST   = 5'h00;
    localparam logic [4:0] HOLD_FALL  = 5'h03;  // sample frozen here
    localparam logic [4:0] CONV_FALLS = 5'h14;  // 20 input clocks
    // divided clock ticks (input clock / 2)
    localparam logic [3:0] TICK_RST   = 4'h0;
    localparam logic [3:0] CLEAR_TICK = 4'h1;   // register cleared
    localparam logic [3:0] TRIAL_TICK = 4'h2;   // first bit trial

    // data path
    localparam int DATA_W = 8;
    typedef logic [DATA_W-1:0] sacs_data_t;
    localparam sacs_data_t DATA_RST  = 8'h00;
    localparam sacs_data_t TRIAL_MSB = 8'h80;

    // sequencer states
    typedef enum logic [1:0] {
        SACS_IDLE,
        SACS_SAMPLE,
        SACS_CONVERT
    } sacs_state_t;
endpackage

// File: hw/sacs_clk_if.sv
// clock-source signals between the sequencer and its clock generator
interface sacs_clk_if;
    logic run;      // conversion active, enables oscillator and divider
    logic osc_sel;  // 1: internal oscillator, 0: clock pin
    logic fall;     // one-cycle pulse on each selected clock falling edge
    logic tick;     // one-cycle pulse per divided clock period

    modport gen (input run, input osc_sel, output fall, output tick);
    modport seq (output run, output osc_sel, input fall, input tick);
endinterface

// File: hw/sacs_clkgen.sv
// clock source select, internal oscillator and divide-by-two
module sacs_clkgen (
    // system
    input  wire logic mclk_i,
    input  wire logic resetn_i,
    // external clock pin level
    input  wire logic clk_pin_i,
    // sequencer side
    sacs_clk_if.gen   ck
);
    // all generator state
    typedef struct packed {
        logic [3:0] osc_cnt;  // oscillator half period counter
        logic       osc_clk;  // internal oscillator level
        logic       pin_prev; // previous selected clock level
        logic       div_ph;   // divided clock phase
    } sacs_gen_t;

    sacs_gen_t gen_reg;
    sacs_gen_t gen_next;
    logic      src_now;   // selected clock level

    assign src_now = ck.osc_sel ? gen_reg.osc_clk : clk_pin_i;
    assign ck.fall = gen_reg.pin_prev & ~src_now;
    assign ck.tick = ck.fall & ck.run & ~gen_reg.div_ph;

    // next-state logic
    always_comb begin
        gen_next          = gen_reg;
        gen_next.pin_prev = src_now;
        if (!ck.run || !ck.osc_sel) begin
            // idle oscillator parks low so the next start is clean
            gen_next.osc_cnt = sacs_pkg::OSC_CNT_RST;
            gen_next.osc_clk = 1'b0;
        end else if (gen_reg.osc_cnt == sacs_pkg::OSC_HALF - 4'h1) begin
            gen_next.osc_cnt = sacs_pkg::OSC_CNT_RST;
            gen_next.osc_clk = ~gen_reg.osc_clk;
        end else begin
            gen_next.osc_cnt = gen_reg.osc_cnt + 4'h1;
        end
        if (!ck.run) begin
            gen_next.div_ph = 1'b0;
        end else if (ck.fall) begin
            gen_next.div_ph = ~gen_reg.div_ph;
        end
    end

    // state register
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            gen_reg <= '0;
        end else begin
            gen_reg <= gen_next;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    gate_idle_a: assert property (!ck.run |-> !ck.tick)
        else $error("divided clock ticked while idle");
    div_half_a: assert property (
        ck.tick |-> !gen_reg.div_ph ##0 ck.fall ##1 gen_reg.div_ph)
        else $error("divided clock not half the input rate");
    osc_stop_a: assert property (!ck.run |=> !gen_reg.osc_clk)
        else $error("internal oscillator ran while idle");
endmodule // sacs_clkgen

// File: hw/sacs_sequencer.sv
// conversion sequencer for an 8-bit successive-approximation converter
module sacs_sequencer (
    // system
    input  wire logic              mclk_i,
    input  wire logic              resetn_i,
    // host bus strobes
    input  wire logic              cs_n_i,
    input  wire logic              rd_n_i,
    // clock pin and source select
    input  wire logic              clk_pin_i,
    input  wire logic              osc_sel_i,
    // analog front end
    input  wire logic              cmp_i,
    output logic                   track_o,
    output sacs_pkg::sacs_data_t   dac_code_o,
    // host bus outputs
    output logic                   busy_n_o,
    output sacs_pkg::sacs_data_t   data_o,
    output logic                   data_oe_n_o,
    output logic                   osc_run_o
);
    // all sequencer state
    typedef struct packed {
        sacs_pkg::sacs_state_t state;    // sequencer state
        logic [4:0]            fall_cnt; // selected clock falling edges since start
        logic [3:0]            tick_cnt; // divided clock ticks since start
        sacs_pkg::sacs_data_t  appr;     // approximation register
        sacs_pkg::sacs_data_t  trial;    // one-hot bit under trial
        sacs_pkg::sacs_data_t  result;   // output latch
        logic                  busy_n;   // busy, active low
        logic                  window;   // one pin clock after done
        logic                  rd_prev;  // read strobe last cycle
        logic                  drive;    // data bus driven
        logic                  armed;    // a clean cycle since reset
    } sacs_seq_t;

    sacs_seq_t seq_reg;
    sacs_seq_t seq_next;
    logic      rd_act;    // chip select and read both low
    logic      rd_start;  // leading edge of a read access
    logic      done;      // last falling edge of a conversion
    logic [3:0] tick_new; // tick count including this tick

    sacs_clk_if ck ();

    // clock generator shares the conversion enable
    sacs_clkgen u_clkgen (
        .mclk_i    (mclk_i),
        .resetn_i  (resetn_i),
        .clk_pin_i (clk_pin_i),
        .ck        (ck.gen)
    );

    assign ck.osc_sel = osc_sel_i;
    assign ck.run     = (seq_reg.state != sacs_pkg::SACS_IDLE);

    assign rd_act   = ~cs_n_i & ~rd_n_i;
    assign rd_start = rd_act & ~seq_reg.rd_prev;
    assign done     = ck.fall && (seq_reg.state == sacs_pkg::SACS_CONVERT)
                      && (seq_reg.fall_cnt == sacs_pkg::CONV_FALLS - 5'h01);
    assign tick_new = seq_reg.tick_cnt + 4'h1;

    // outputs from state flops; osc_run_o also takes osc_sel_i directly
    // track between conversions
    assign track_o     = (seq_reg.state != sacs_pkg::SACS_CONVERT);
    assign dac_code_o  = seq_reg.appr;
    assign busy_n_o    = seq_reg.busy_n;
    // code is plain binary; offset binary in bipolar wiring
    assign data_o      = seq_reg.result;
    assign data_oe_n_o = ~seq_reg.drive;
    assign osc_run_o   = ck.run & osc_sel_i;

    // next-state logic
    always_comb begin
        seq_next         = seq_reg;
        seq_next.rd_prev = rd_act;
        seq_next.drive   = rd_act;
        // checks may use history once a cycle has passed after reset
        seq_next.armed   = 1'b1;
        // window closes after one pin clock; the stopped internal
        // oscillator has no period, so that mode keeps no window open
        if (ck.fall || osc_sel_i) begin
            seq_next.window = 1'b0;
        end
        // count selected clock falling edges while active
        if (ck.run && ck.fall) begin
            seq_next.fall_cnt = seq_reg.fall_cnt + 5'h01;
        end
        case (seq_reg.state)
            sacs_pkg::SACS_IDLE: begin
                if (rd_start && !seq_reg.window) begin
                    seq_next.state    = sacs_pkg::SACS_SAMPLE;
                    seq_next.busy_n   = 1'b0;
                    seq_next.fall_cnt = sacs_pkg::FALL_RST;
                    seq_next.tick_cnt = sacs_pkg::TICK_RST;
                end
            end
            sacs_pkg::SACS_SAMPLE: begin
                if (ck.fall &&
                    seq_reg.fall_cnt == sacs_pkg::HOLD_FALL - 5'h01) begin
                    seq_next.state = sacs_pkg::SACS_CONVERT;
                end
            end
            sacs_pkg::SACS_CONVERT: begin
                // old data on reads
                // reads here only see old data; the host must wait
                if (done) begin
                    seq_next.result = cmp_i ? seq_reg.appr
                                            : (seq_reg.appr & ~seq_reg.trial);
                    seq_next.state  = sacs_pkg::SACS_IDLE;
                    seq_next.busy_n = 1'b1;
                    // no window when the oscillator stops with the result
                    seq_next.window = ~osc_sel_i;
                end
            end
            default: begin
                seq_next.state = sacs_pkg::SACS_IDLE;
            end
        endcase
        // bit decisions on divided clock ticks
        if (ck.tick) begin
            seq_next.tick_cnt = tick_new;
            if (tick_new == sacs_pkg::CLEAR_TICK) begin
                seq_next.appr  = sacs_pkg::DATA_RST;
                seq_next.trial = sacs_pkg::DATA_RST;
            end else if (tick_new == sacs_pkg::TRIAL_TICK) begin
                seq_next.appr  = sacs_pkg::TRIAL_MSB;
                seq_next.trial = sacs_pkg::TRIAL_MSB;
            end else if (seq_reg.trial != sacs_pkg::DATA_RST) begin
                // keep the last bit if input is at or above the trial
                seq_next.trial = seq_reg.trial >> 1;
                seq_next.appr  = (cmp_i ? seq_reg.appr
                                        : (seq_reg.appr & ~seq_reg.trial))
                                 | (seq_reg.trial >> 1);
            end
        end
    end

    // state register
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            seq_reg        <= '0;
            seq_reg.state  <= sacs_pkg::SACS_IDLE;
            seq_reg.busy_n <= 1'b1;
        end else begin
            seq_reg <= seq_next;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    // history sampled before the first reset edge is unknown, so the
    // checks wait for one clean cycle after reset
    default disable iff (!resetn_i || !seq_reg.armed);

    busy_start_a: assert property (
        seq_reg.state == sacs_pkg::SACS_IDLE && rd_start && !seq_reg.window
        |=> !busy_n_o)
        else $error("busy did not fall at conversion start");
    hold_third_a: assert property (
        $fell(track_o) |-> seq_reg.fall_cnt == sacs_pkg::HOLD_FALL)
        else $error("sample held on the wrong edge");
    conv_len_a: assert property (
        $rose(busy_n_o) |->
        $past(seq_reg.fall_cnt) == sacs_pkg::CONV_FALLS - 5'h01
        ##0 seq_reg.tick_cnt == 4'ha)
        else $error("conversion length not twenty pin clocks");
    track_idle_a: assert property (busy_n_o |-> track_o)
        else $error("input not tracked while idle");
    appr_clear_a: assert property (
        ck.tick && seq_reg.tick_cnt == sacs_pkg::TICK_RST
        |=> dac_code_o == sacs_pkg::DATA_RST)
        else $error("approximation register not cleared");
    latch_done_a: assert property (
        $changed(data_o) |-> $past(done))
        else $error("result changed outside completion");
    read_drive_a: assert property (rd_act |=> !data_oe_n_o)
        else $error("read did not drive the data bus");
    no_restart_a: assert property (
        seq_reg.window && rd_start &&
        seq_reg.state == sacs_pkg::SACS_IDLE |=> busy_n_o [*2])
        else $error("read right after done restarted conversion");
    busy_read_a: assert property (
        !busy_n_o && rd_act && !done |=> $stable(data_o))
        else $error("read during conversion changed data");

    conv_done_c: cover property ($rose(busy_n_o));
    window_read_c: cover property (seq_reg.window && rd_start);
    busy_read_c: cover property (!busy_n_o && rd_act);
    osc_conv_c: cover property (osc_sel_i && $rose(busy_n_o));
endmodule // sacs_sequencer

// File: verification/sacs_front_model.sv
// pin clock source and sample-and-compare model of the analog side
module sacs_front_model (
    // system
    input  wire logic                 mclk_i,
    // analog level, trial code and sample stage mode
    input  wire sacs_pkg::sacs_data_t analog_input_i,
    input  wire sacs_pkg::sacs_data_t dac_code_i,
    input  wire logic                 track_i,
    // toward the sequencer
    output logic                      clk_pin_o,
    output logic                      cmp_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0]           half_cnt;   // system clocks in this level
    sacs_pkg::sacs_data_t held;       // level on the hold capacitor
    initial begin
        clk_pin_o = 1'b1;
        half_cnt  = 3'h0;
    end
    always @(posedge mclk_i) begin
        half_cnt <= (half_cnt == 3'h4) ? 3'h0 : half_cnt + 3'h1;
        if (half_cnt == 3'h4) begin
            clk_pin_o <= ~clk_pin_o;
        end
    end
    always @(posedge mclk_i) begin
        if (track_i) begin
            held <= analog_input_i;
        end
    end
    assign cmp_o = (held >= dac_code_i);
endmodule // sacs_front_model

// File: verification/test_sar_adc_conversion_sequencer.sv
// self-checking bench for the conversion sequencer
module test_sar_adc_conversion_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 mclk_i = 0, resetn_i = 0, cs_n_i = 1, rd_n_i = 1;
    logic                 osc_sel_i = 0, clk_pin_i, cmp_i, track_o;
    logic                 busy_n_o, data_oe_n_o, osc_run_o;
    sacs_pkg::sacs_data_t dac_code_o, data_o, analog_input = 8'h00,
                          last = 8'h00;
    logic [31:0]          rs = 32'hedc75356;  // xorshift state
    int                   fail_count = 0, checks = 0, cyc = 0, fall_cnt = 0;
    int                   exp_q[$];           // results awaiting completion
    logic                 pin_q = 1, seen_zero = 0;
    always #12.5 mclk_i = ~mclk_i;
    sacs_sequencer uut (.mclk_i(mclk_i), .resetn_i(resetn_i), .cs_n_i(cs_n_i),
        .rd_n_i(rd_n_i), .clk_pin_i(clk_pin_i), .osc_sel_i(osc_sel_i),
        .cmp_i(cmp_i), .track_o(track_o), .dac_code_o(dac_code_o),
        .busy_n_o(busy_n_o), .data_o(data_o), .data_oe_n_o(data_oe_n_o),
        .osc_run_o(osc_run_o));
    sacs_front_model front (.mclk_i(mclk_i), .analog_input_i(analog_input),
        .dac_code_i(dac_code_o), .track_i(track_o), .clk_pin_o(clk_pin_i),
        .cmp_o(cmp_i));
    // pin falls, clear seen, hang guard
    always @(posedge mclk_i) begin
        pin_q <= clk_pin_i;
        if (pin_q && !clk_pin_i) fall_cnt <= fall_cnt + 1;
        if (busy_n_o === 1'b1) seen_zero <= 0;
        else if (dac_code_o === 8'h00) seen_zero <= 1;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [7:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick();
        @(posedge mclk_i);
        #1;
    endtask
    // next value of the xorshift random stream
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        v = v ^ (v << 5);
        return v;
    endfunction
    // one read strobe: latched result must be on the bus
    task automatic rd_pulse();
        @(posedge mclk_i);
        cs_n_i <= 0;
        rd_n_i <= 0;
        tick();
        check("oe_n", data_oe_n_o, 0);
        check("data", data_o, last);
        @(posedge mclk_i);
        cs_n_i <= 1;
        rd_n_i <= 1;
    endtask
    // one conversion: pin or internal clock, strobe held or released,
    // and optionally a read while busy
    task automatic conv(input logic osc, hold, mid);
        int base, n;
        logic [7:0] d;
        rs = xorshift(rs);
        @(posedge mclk_i);
        analog_input <= rs[7:0];
        osc_sel_i <= osc;
        if (!osc) begin
            @(negedge clk_pin_i);
            @(posedge clk_pin_i);
        end
        @(posedge mclk_i);
        base = fall_cnt;
        cs_n_i <= 0;
        rd_n_i <= 0;
        tick();
        check("busy_n", busy_n_o, 0);
        check("data", data_o, last);
        if (!hold) begin
            @(posedge mclk_i);
            cs_n_i <= 1;
            rd_n_i <= 1;
        end
        for (n = 0; n < 400 && track_o !== 0; n++) tick();
        exp_q.push_back(int'(analog_input));
        // the held sample must no longer follow the input
        analog_input <= ~analog_input;
        check("cleared", seen_zero, 1);
        check("osc_run", osc_run_o, osc);
        if (!osc) check("hold_fall", 8'(fall_cnt - base), 3);
        if (mid) rd_pulse();
        if (mid) check("busy_mid", busy_n_o, 0);
        for (n = 0; n < 400 && busy_n_o !== 1; n++) tick();
        last = 8'(exp_q.pop_front());
        if (!osc) check("conv_fall", 8'(fall_cnt - base), 20);
        check("result", data_o, last);
        check("track", track_o, 1);
        check("osc_stop", osc_run_o, 0);
        if (hold) begin
            check("oe_held", data_oe_n_o, 0);
            @(posedge mclk_i);
            cs_n_i <= 1;
            rd_n_i <= 1;
        end
        if (!osc) begin
            rd_pulse();
            d = dac_code_o;
            n = 0;
            repeat (30) begin
                tick();
                if (busy_n_o !== 1) n++;
            end
            check("no_start", 8'(n), 0);
            check("gated", dac_code_o, d);
        end
    endtask
    initial begin
        repeat (2) @(posedge mclk_i);
        resetn_i <= 1;
        tick();
        check("rst_busy", busy_n_o, 1);
        check("rst_track", track_o, 1);
        check("rst_oe", data_oe_n_o, 1);
        check("rst_data", data_o, 8'h00);
        check("rst_osc", osc_run_o, 0);
        conv(0, 0, 0);
        conv(0, 1, 0);
        conv(1, 0, 1);
        conv(0, 0, 1);
        conv(1, 1, 0);
        // back to back on the internal oscillator must restart
        conv(1, 0, 0);
        conv(0, 1, 0);
        test_done();
    end
endmodule // test_sar_adc_conversion_sequencer
